/* File: hw/smt_count_if.sv */
/*
  Carrier between the timer's register side and its counter core.
  Assumes both ends sit in the sys_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface smt_count_if #(parameter int W = 16);
  logic         load;
  logic [W-1:0] load_val;
  logic         tick;
  logic [W-1:0] compare;
  logic [W-1:0] count;
  logic         hit;

  modport ctrl
  (
    output load, load_val, tick, compare,
    input  count, hit
  );

  modport core
  (
    input  load, load_val, tick, compare,
    output count, hit
  );
endinterface
`default_nettype wire

/* File: hw/smt_counter.sv */
/*
  Up-counter core of the match timer: load, count on tick, clear on match.
  Assumes tick and load are synchronous single-cycle qualifiers.
*/
`timescale 1ns/1ps
`default_nettype none
module smt_counter
  import smt_pkg::*;
#(
  parameter int W = 16
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register side
  smt_count_if.core cif
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  wire  logic   at_compare;
  wire  logic   hit;

  assign at_compare = (count == cif.compare);
  assign hit        = cif.tick & at_compare;

  // a load from software beats any tick in the same cycle
  assign next_count = cif.load ? cif.load_val
                    : hit      ? '0
                    : cif.tick ? W'(count + W'(1))
                    : count;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      count <= '0;
    else
      count <= next_count;
  end

  assign cif.count = count;
  assign cif.hit   = hit;

endmodule
`default_nettype wire

/* File: hw/smt_pkg.sv */
/*
  Constants for the sixteen-bit match timer channel: register offsets,
  field positions, reset values and output command codes.
  Assumes a 32-bit APB register bus with word-aligned byte addresses.
*/
package smt_pkg;

  localparam int APB_DW = 32;

  // register byte offsets
  localparam logic [7:0] OFF_ENABLE  = 8'h00;
  localparam logic [7:0] OFF_RUN     = 8'h04;
  localparam logic [7:0] OFF_CONTROL = 8'h08;
  localparam logic [7:0] OFF_COMPARE = 8'h0C;
  localparam logic [7:0] OFF_COUNTER = 8'h10;

  // field positions
  localparam int EN_HALT_BIT    = 1;
  localparam int RUN_BIT        = 0;
  localparam int CR_CLK_BIT     = 0;
  localparam int CR_CMD_LO      = 4;
  localparam int CR_CMD_HI      = 5;
  localparam int CR_TOGGLE_BIT  = 7;
  localparam int CR_SPARE_BIT   = 15;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic        RST_BIT  = 1'b0;
  localparam logic        RST_PIN  = 1'b0;

  // software output command codes
  localparam logic [1:0] CMD_INVERT = 2'h0;
  localparam logic [1:0] CMD_SET    = 2'h1;
  localparam logic [1:0] CMD_CLEAR  = 2'h2;
  localparam logic [1:0] CMD_HOLD   = 2'h3;

  // clock source select values
  localparam logic SRC_SYSCLK = 1'b0;
  localparam logic SRC_TAP    = 1'b1;

endpackage

/* File: hw/smt_timer.sv */
/*
  One channel of a sixteen-bit match timer with an APB register slave,
  a toggling output flip-flop and a one-cycle match interrupt pulse.
  Assumes APB signals, the prescaler tap and the debug halt level are all
  synchronous to sys_clk; the tap is a one-cycle enable, not a clock.
*/
// Function
// - run bit 1 lets the counter count on the chosen source; 0 holds it
// - count equal to compare clears to zero and counting continues
// - every compare match raises a match interrupt
// - clearing run stops the counter and keeps its value
// - counter register reads the live count and writes load it
// - compare register holds sixteen bits; software never writes zero
// - control bit 0 picks system clock or first prescaler tap
// - control bit 7 makes each match invert the output; a command 00, 01 or 10 written in the same cycle wins
// - output command 00 invert, 01 set, 10 clear, 11 nothing; reads 11
// - output is low after reset
// - stopped counter leaves the output at its last level
// - halt control 0 pauses counting during debug halt, resumes after
`timescale 1ns/1ps
`default_nettype none
module smt_timer
  import smt_pkg::*;
#(
  parameter int COUNT_W = 16,
  parameter int ADDR_W  = 8
)
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // apb slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_DW-1:0] pwdata,
  output logic      [APB_DW-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // count sources
  input  wire logic              first_prescaler_tap,
  input  wire logic              debug_halt,
  // timer outputs
  output logic                   match_interrupt,
  output logic                   timer_output_pin
);

  generate
    if (COUNT_W < 1 || COUNT_W > 16)
    begin : g_bad_width
      $error("smt_timer: COUNT_W must be 1 to 16");
    end
    if (ADDR_W < 5 || ADDR_W > 8)
    begin : g_bad_addr
      $error("smt_timer: ADDR_W must be 5 to 8");
    end
  endgenerate

  // software-visible state
  logic               halt_ctrl;
  logic               count_run;
  logic               clk_sel;
  logic               toggle_on_match_enable;
  logic               spare_bit;
  logic [COUNT_W-1:0] compare_value;

  // bus decode
  wire logic [7:0] addr8;
  wire logic       setup_phase;
  wire logic       access_done;
  wire logic       wr_done;
  wire logic       sel_enable;
  wire logic       sel_run;
  wire logic       sel_control;
  wire logic       sel_compare;
  wire logic       sel_counter;
  wire logic       addr_mapped;
  wire logic       wr_enable;
  wire logic       wr_run;
  wire logic       wr_control;
  wire logic       wr_compare;
  wire logic       wr_counter;

  // count qualifiers
  wire logic halt_pause;
  wire logic source_tick;
  wire logic count_tick;

  // output command
  wire logic [1:0] software_output_command;
  wire logic       cmd_write;
  wire logic       next_pin;
  wire logic       cmd_invert;
  wire logic       cmd_set;
  wire logic       cmd_clear;
  wire logic       match_toggle;

  // next register values
  wire logic               next_halt_ctrl;
  wire logic               next_count_run;
  wire logic               next_clk_sel;
  wire logic               next_toggle_en;
  wire logic               next_spare_bit;
  wire logic [COUNT_W-1:0] next_compare;
  wire logic               next_match_irq;
  wire logic               next_pready;
  wire logic               next_pslverr;

  // read-back words
  wire logic [APB_DW-1:0] rd_enable;
  wire logic [APB_DW-1:0] rd_run;
  wire logic [APB_DW-1:0] rd_control;
  wire logic [APB_DW-1:0] rd_compare;
  wire logic [APB_DW-1:0] rd_counter;
  wire logic [APB_DW-1:0] rd_word;
  wire logic [APB_DW-1:0] next_prdata;

  smt_count_if #(.W(COUNT_W)) cif ();

  smt_counter #(.W(COUNT_W)) u_counter
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .cif     (cif)
  );

  // the address may be narrower than a byte; upper bits read as zero
  assign addr8 = 8'(paddr);

  assign sel_enable  = (addr8 == OFF_ENABLE);
  assign sel_run     = (addr8 == OFF_RUN);
  assign sel_control = (addr8 == OFF_CONTROL);
  assign sel_compare = (addr8 == OFF_COMPARE);
  assign sel_counter = (addr8 == OFF_COUNTER);

  assign addr_mapped = sel_enable
                     | sel_run
                     | sel_control
                     | sel_compare
                     | sel_counter;

  // pready rises for the cycle after setup, so no access has a wait state
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign wr_done     = access_done & pwrite & addr_mapped;

  // one write strobe per register; unmapped writes are dropped
  assign wr_enable  = wr_done & sel_enable;
  assign wr_run     = wr_done & sel_run;
  assign wr_control = wr_done & sel_control;
  assign wr_compare = wr_done & sel_compare;
  assign wr_counter = wr_done & sel_counter;

  // halt control 0 means pause while the core is halted
  assign halt_pause  = debug_halt & ~halt_ctrl;

  assign source_tick = (clk_sel == SRC_TAP) ? first_prescaler_tap
                                            : 1'b1;

  // the tap is an enable: a tap held high for two cycles counts twice
  assign count_tick  = count_run & ~halt_pause & source_tick;

  // counter core hookup
  assign cif.tick     = count_tick;
  assign cif.compare  = compare_value;
  assign cif.load     = wr_counter;
  assign cif.load_val = pwdata[COUNT_W-1:0];

  // next register values: hold unless this access writes the register
  assign next_halt_ctrl = wr_enable  ? pwdata[EN_HALT_BIT]   : halt_ctrl;
  assign next_count_run = wr_run     ? pwdata[RUN_BIT]       : count_run;
  assign next_clk_sel   = wr_control ? pwdata[CR_CLK_BIT]    : clk_sel;
  assign next_toggle_en = wr_control ? pwdata[CR_TOGGLE_BIT] : toggle_on_match_enable;
  assign next_spare_bit = wr_control ? pwdata[CR_SPARE_BIT]  : spare_bit;
  assign next_compare   = wr_compare ? pwdata[COUNT_W-1:0]   : compare_value;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      halt_ctrl <= RST_BIT;
    else
      halt_ctrl <= next_halt_ctrl;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      count_run <= RST_BIT;
    else
      count_run <= next_count_run;
  end

  // config changes are expected only while stopped; they are not blocked
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      clk_sel <= SRC_SYSCLK;
    else
      clk_sel <= next_clk_sel;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      toggle_on_match_enable <= RST_BIT;
    else
      toggle_on_match_enable <= next_toggle_en;
  end

  // spare bit is plain storage with no effect on the timer
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      spare_bit <= RST_BIT;
    else
      spare_bit <= next_spare_bit;
  end

  // a zero compare value would match at once and never count; not guarded
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      compare_value <= RST_WORD[COUNT_W-1:0];
    else
      compare_value <= next_compare;
  end

  // output flip-flop: a software command 00, 01 or 10 wins over a match toggle
  assign software_output_command = pwdata[CR_CMD_HI:CR_CMD_LO];
  assign cmd_write = wr_control;

  assign cmd_invert   = cmd_write & (software_output_command == CMD_INVERT);
  assign cmd_set      = cmd_write & (software_output_command == CMD_SET);
  assign cmd_clear    = cmd_write & (software_output_command == CMD_CLEAR);
  assign match_toggle = cif.hit & toggle_on_match_enable;

  assign next_pin = cmd_invert   ? ~timer_output_pin
                  : cmd_set      ? 1'b1
                  : cmd_clear    ? 1'b0
                  : match_toggle ? ~timer_output_pin
                  : timer_output_pin;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      timer_output_pin <= RST_PIN;
    else
      timer_output_pin <= next_pin;
  end

  // interrupt pulse follows the match edge by one cycle
  assign next_match_irq = cif.hit;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      match_interrupt <= RST_BIT;
    else
      match_interrupt <= next_match_irq;
  end

  // read-back words
  assign rd_enable = APB_DW'({halt_ctrl, 1'b0});

  assign rd_run = APB_DW'(count_run);

  assign rd_control = APB_DW'({spare_bit,
                               7'h00,
                               toggle_on_match_enable,
                               1'b0,
                               CMD_HOLD,
                               3'h0,
                               clk_sel});

  assign rd_compare = APB_DW'(compare_value);

  // live count, taken in the setup cycle of the read
  assign rd_counter = APB_DW'(cif.count);

  assign rd_word = (pwrite)      ? RST_WORD
                 : sel_enable    ? rd_enable
                 : sel_run       ? rd_run
                 : sel_control   ? rd_control
                 : sel_compare   ? rd_compare
                 : sel_counter   ? rd_counter
                 : RST_WORD;

  // answer stands one cycle; read data falls back to zero after the access
  assign next_pready  = setup_phase;
  assign next_pslverr = setup_phase & ~addr_mapped;
  assign next_prdata  = setup_phase ? rd_word
                      : access_done ? RST_WORD
                      : prdata;

  // apb answer registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      pready <= RST_BIT;
    else
      pready <= next_pready;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      pslverr <= RST_BIT;
    else
      pslverr <= next_pslverr;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      prdata <= RST_WORD;
    else
      prdata <= next_prdata;
  end

endmodule
`default_nettype wire

/* File: verif/smt_timer_props.sv */
/*
  Checker for the match timer: read fields, output pin and interrupt.
  Assumes it is bound to smt_timer and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module smt_timer_props
  import smt_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              rst,
  // apb
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [APB_DW-1:0] pwdata,
  input wire logic [APB_DW-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // sources and outputs
  input wire logic              first_prescaler_tap,
  input wire logic              debug_halt,
  input wire logic              match_interrupt,
  input wire logic              timer_output_pin
);
  wire logic acc   = psel && penable && pready;
  wire logic rd    = acc && !pwrite;
  wire logic wr_cr = acc && pwrite && paddr == OFF_CONTROL;
  wire logic [1:0] cmd = pwdata[CR_CMD_HI:CR_CMD_LO];
  // shadow copies of the fields that gate counting, plus the match toggle enable
  logic run_q, sel_q, toggle_on_match_enable_q, halt_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      run_q  <= 1'b0;
      sel_q  <= 1'b0;
      toggle_on_match_enable_q <= 1'b0;
      halt_q <= 1'b0;
    end
    else if (acc && pwrite)
    begin
      if (paddr == OFF_RUN) run_q <= pwdata[RUN_BIT];
      if (paddr == OFF_ENABLE) halt_q <= pwdata[EN_HALT_BIT];
      if (wr_cr) sel_q <= pwdata[CR_CLK_BIT];
      if (wr_cr) toggle_on_match_enable_q <= pwdata[CR_TOGGLE_BIT];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_irq_pulse: assert property (match_interrupt |=> !match_interrupt)
    else $error("interrupt longer than one cycle");
  a_pin_reset: assert property (disable iff (1'b0) rst |=> !timer_output_pin)
    else $error("pin not low after reset");
  a_stop_no_irq: assert property (!$past(run_q) |-> !match_interrupt)
    else $error("interrupt while stopped");
  a_tap_gate: assert property ($past(sel_q) && !$past(first_prescaler_tap) |->
    !match_interrupt)
    else $error("interrupt without tap");
  a_halt_pause: assert property ($past(debug_halt) && !$past(halt_q) |->
    !match_interrupt)
    else $error("interrupt during halt");
  a_match_toggle: assert property (match_interrupt && !$past(wr_cr) |->
    (timer_output_pin != $past(timer_output_pin)) == $past(toggle_on_match_enable_q))
    else $error("pin toggle on match wrong");
  a_cmd_effect: assert property ($past(wr_cr) && $past(cmd) != CMD_HOLD |->
    timer_output_pin == ($past(cmd) == CMD_INVERT ? !$past(timer_output_pin)
    : $past(cmd) == CMD_SET))
    else $error("output command wrong");
  a_pin_cause: assert property ($changed(timer_output_pin) |->
    match_interrupt || $past(wr_cr))
    else $error("pin changed without cause");
  a_cmd_reads: assert property (rd && paddr == OFF_CONTROL |->
    prdata[CR_CMD_HI:CR_CMD_LO] == CMD_HOLD)
    else $error("command field not read as 11");
  a_cnt_upper: assert property (rd && paddr == OFF_COUNTER |-> prdata[31:16] == 16'h0000)
    else $error("counter upper bits set");
endmodule

bind smt_timer smt_timer_props #(.ADDR_W(ADDR_W)) u_props (
  .sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .first_prescaler_tap(first_prescaler_tap),
  .debug_halt(debug_halt), .match_interrupt(match_interrupt),
  .timer_output_pin(timer_output_pin));
`default_nettype wire

/* File: verif/tb_sixteen_bit_match_timer.sv */
/*
  Self-checking bench for the match timer channel, driven over APB.
  Assumes smt_timer at default parameters with its checker bound in.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_sixteen_bit_match_timer
  import smt_pkg::*;
;
  logic        sys_clk, rst, psel, penable, pwrite, serr, p;
  logic        first_prescaler_tap = 1'b0;
  logic        debug_halt, match_interrupt, timer_output_pin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, v, hold_v;
  logic        pready, pslverr;
  int          errors, checks, n, i;
  int          tdiv = 0;
  logic [7:0]  offs [5] = '{OFF_ENABLE, OFF_RUN, OFF_CONTROL, OFF_COMPARE, OFF_COUNTER};
  logic [1:0]  cmds [4] = '{CMD_SET, CMD_CLEAR, CMD_INVERT, CMD_HOLD};
  logic        pexp [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

  smt_timer DUT (
    .sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .first_prescaler_tap(first_prescaler_tap),
    .debug_halt(debug_halt), .match_interrupt(match_interrupt),
    .timer_output_pin(timer_output_pin));

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // tap every third cycle, so the tap period differs from the system clock
  always @(posedge sys_clk)
  begin
    tdiv <= (tdiv == 2) ? 0 : tdiv + 1;
    first_prescaler_tap <= (tdiv == 2);
  end

  task close_out;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task hang;
    errors++;
    $display("[ERR] %0t wait ran out", $time);
    close_out();
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) hang();
    v = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_irq;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (match_interrupt !== 1'b1 && n < 300);
    if (n >= 300) hang();
  endtask

  task start(input logic [31:0] cr, input logic [31:0] cmp);
    apb(1'b1, OFF_RUN, 32'h0000_0000);
    apb(1'b1, OFF_CONTROL, cr);
    apb(1'b1, OFF_COMPARE, cmp);
    apb(1'b1, OFF_COUNTER, 32'h0000_0000);
    apb(1'b1, OFF_RUN, 32'h0000_0001);
  endtask

  initial
  begin
    rst        = 1'b1;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0000_0000;
    debug_halt = 1'b0;
    errors = 0;
    checks = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk({31'h0, timer_output_pin}, 32'h0000_0000);
    for (i = 0; i < 5; i++)
    begin
      apb(1'b0, offs[i], 32'h0000_0000);
      chk(v, (i == 2) ? 32'h0000_0030 : 32'h0000_0000);
    end
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk({serr, v[30:0]}, 32'h8000_0000);
    for (i = 0; i < 4; i++)
    begin
      apb(1'b1, OFF_CONTROL, {26'h0, cmds[i], 4'h0});
      @(negedge sys_clk);
      chk({31'h0, timer_output_pin}, {31'h0, pexp[i]});
    end
    apb(1'b1, OFF_COUNTER, 32'h0000_1234);
    apb(1'b0, OFF_COUNTER, 32'h0000_0000);
    chk(v, 32'h0000_1234);
    apb(1'b1, OFF_COMPARE, 32'h0001_ABCD);
    apb(1'b0, OFF_COMPARE, 32'h0000_0000);
    chk(v, 32'h0000_ABCD);
    start(32'h0000_00B0, 32'h0000_0003);
    wait_irq();
    p = timer_output_pin;
    wait_irq();
    chk(32'(n), 32'h0000_0004);
    chk({31'h0, timer_output_pin}, {31'h0, ~p});
    apb(1'b1, OFF_RUN, 32'h0000_0000);
    apb(1'b0, OFF_COUNTER, 32'h0000_0000);
    hold_v = v;
    p = timer_output_pin;
    repeat (10) @(posedge sys_clk);
    apb(1'b0, OFF_COUNTER, 32'h0000_0000);
    chk(v, hold_v);
    chk({31'h0, timer_output_pin}, {31'h0, p});
    start(32'h0000_0031, 32'h0000_0003);
    wait_irq();
    p = timer_output_pin;
    wait_irq();
    chk(32'(n), 32'h0000_000C);
    chk({31'h0, timer_output_pin}, {31'h0, p});
    start(32'h0000_0030, 32'h0000_0005);
    @(posedge sys_clk);
    debug_halt <= 1'b1;
    apb(1'b0, OFF_COUNTER, 32'h0000_0000);
    hold_v = v;
    repeat (20) @(posedge sys_clk);
    apb(1'b0, OFF_COUNTER, 32'h0000_0000);
    chk(v, hold_v);
    debug_halt <= 1'b0;
    wait_irq();
    wait_irq();
    chk(32'(n), 32'h0000_0006);
    apb(1'b1, OFF_RUN, 32'h0000_0000);
    apb(1'b1, OFF_ENABLE, 32'h0000_0002);
    start(32'h0000_0030, 32'h0000_0005);
    debug_halt <= 1'b1;
    wait_irq();
    wait_irq();
    chk(32'(n), 32'h0000_0006);
    close_out();
  end
endmodule
`default_nettype wire
